// *** hdl/flash_programming_port.sv ***
// device side of the parallel flash programming port with apb status access
//
// Decided for this implementation: the address map and the APB interface to the registers.
`include "flash_port_consts.svh"
`default_nettype none
module flash_programming_port #(
  parameter int FLASH_WORDS = 256, // words of flash array
  parameter int PAGE_WORDS = 32 // words of one page, at most 256
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // programmer pins
  input wire flash_port_pkg::prog_pins_t pins,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic ready_busy_out,
  // core side
  input wire logic ivec_in_boot,
  input wire logic exec_in_app,
  output flash_port_pkg::lock_policy_t policy,
  output logic [7:0] lock_byte
);
  localparam int AW = $clog2(FLASH_WORDS); // flash word address width
  localparam int PW = $clog2(PAGE_WORDS); // word-in-page width

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [15:0] flash_mem [FLASH_WORDS]; // flash array, erased to ones
  logic [15:0] page_buf [PAGE_WORDS]; // page buffer
  logic [7:0] cmd; // latched command
  logic [7:0] addr_lo; // address low byte
  logic [7:0] addr_hi; // address high byte
  logic [7:0] data_lo; // data low byte
  logic [7:0] data_hi; // data high byte
  logic [7:0] lock; // lock byte
  logic [31:0] cal; // four calibration bytes
  logic [15:0] prog_time; // busy length in cycles, one less than the ready/busy low time
  logic [15:0] busy_cnt; // remaining busy cycles
  logic [AW-1:0] prog_page; // page base caught at start
  flash_port_pkg::seq_state_t state; // sequencer state
  flash_port_pkg::prog_pins_t pins_q; // previous pin sample for edges

  // ----------------------------------------
  // pin edges
  // ----------------------------------------
  logic load_rise; // strobe rising edge
  logic latch_rise; // page latch rising edge
  logic wr_fall; // write strobe falling edge
  logic busy; // sequencer working
  logic [1:0] load_sel; // load-select pair
  logic [AW-1:0] word_addr; // full word address

  // word address from both address bytes, cut to the array
  function automatic logic [AW-1:0] flash_addr(input logic [7:0] hi, input logic [7:0] lo);
    logic [15:0] full;
    full = {hi, lo};
    return full[AW-1:0];
  endfunction

  // a pair is programmed when its bit is 0
  function automatic logic [1:0] lock_pair(input logic [7:0] lb, input int lsb);
    return lb[lsb +: 2];
  endfunction

  assign load_rise = pins.load_strobe_clock_input & ~pins_q.load_strobe_clock_input;
  assign latch_rise = pins.page_latch_strobe & ~pins_q.page_latch_strobe;
  assign wr_fall = ~pins.write_strobe_n & pins_q.write_strobe_n;
  assign busy = (state != flash_port_pkg::ST_IDLE);
  assign load_sel = {pins.load_select_high, pins.load_select_low};
  assign word_addr = flash_addr(addr_hi, addr_lo);

  // previous pin sample; reset to idle levels so no false edge at release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pins_q <= '{output_enable_n: 1'b1, write_strobe_n: 1'b1, default: '0};
    end else if (clk_en) begin
      pins_q <= pins;
    end
  end

  // ----------------------------------------
  // command, address and data loading
  // ----------------------------------------
  // loads are ignored while busy so a page cannot change under programming
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= 8'h00;
      addr_lo <= 8'h00;
      addr_hi <= 8'h00;
      data_lo <= 8'h00;
      data_hi <= 8'h00;
    end else if (clk_en && load_rise && !busy) begin
      case (load_sel)
        2'b10: cmd <= pins.data;
        2'b00: begin
          if (pins.byte_select) begin
            addr_hi <= pins.data;
          end else begin
            addr_lo <= pins.data;
          end
        end
        2'b01: begin
          if (pins.byte_select) begin
            data_hi <= pins.data;
          end else begin
            data_lo <= pins.data;
          end
        end
        default: ; // 11 is a no-action load
      endcase
    end
  end

  // ----------------------------------------
  // page buffer
  // ----------------------------------------
  // word picked by low address bits; page bits are ignored here
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (latch_rise && pins.byte_select && !busy) begin
        page_buf[addr_lo[PW-1:0]] <= {data_hi, data_lo};
      end else if (state == flash_port_pkg::ST_PROG && busy_cnt == 16'h0000) begin
        for (int i = 0; i < PAGE_WORDS; i++) begin
          page_buf[i] <= `ERASED_WORD; // buffer emptied after each page
        end
      end
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  logic start_prog; // write flash accepted
  logic start_erase; // chip erase accepted
  logic start_lock; // lock write accepted
  assign start_prog = clk_en && wr_fall && !pins.byte_select && !busy
    && cmd == `CMD_WRITE_FLASH && !policy.flash_write_blocked;
  assign start_erase = clk_en && wr_fall && !busy && cmd == `CMD_CHIP_ERASE;
  assign start_lock = clk_en && wr_fall && !busy && cmd == `CMD_WRITE_LOCK;

  // state and busy counter; ready/busy low for prog_time + 1 cycles
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= flash_port_pkg::ST_IDLE;
      busy_cnt <= 16'h0000;
      prog_page <= '0;
    end else if (clk_en) begin
      case (state)
        flash_port_pkg::ST_IDLE: begin
          if (start_prog) begin
            state <= flash_port_pkg::ST_PROG;
            busy_cnt <= prog_time;
            prog_page <= word_addr & ~AW'(PAGE_WORDS - 1);
          end else if (start_erase) begin
            state <= flash_port_pkg::ST_ERASE;
            busy_cnt <= prog_time;
          end
        end
        flash_port_pkg::ST_PROG, flash_port_pkg::ST_ERASE: begin
          if (busy_cnt == 16'h0000) begin
            state <= flash_port_pkg::ST_IDLE;
          end else begin
            busy_cnt <= busy_cnt - 16'h0001;
          end
        end
        default: state <= flash_port_pkg::ST_IDLE;
      endcase
    end
  end

  // flash array written at the end of a busy period
  always_ff @(posedge clk_sys) begin
    if (clk_en && busy_cnt == 16'h0000) begin
      if (state == flash_port_pkg::ST_PROG) begin
        for (int i = 0; i < PAGE_WORDS; i++) begin
          flash_mem[prog_page + AW'(i)] <= page_buf[i];
        end
      end else if (state == flash_port_pkg::ST_ERASE) begin
        for (int i = 0; i < FLASH_WORDS; i++) begin
          flash_mem[i] <= `ERASED_WORD;
        end
      end
    end
  end

  // ----------------------------------------
  // lock byte
  // ----------------------------------------
  // programming can only clear bits; ones come back by chip erase or reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock <= `LOCK_RST;
    end else if (clk_en) begin
      if (state == flash_port_pkg::ST_ERASE && busy_cnt == 16'h0000) begin
        lock <= `LOCK_RST;
      end else if (start_lock) begin
        lock <= lock & (data_lo | `LOCK_UNUSED_MASK);
      end
    end
  end

  // ----------------------------------------
  // lock policy
  // ----------------------------------------
  // boot pair is reported in lock_byte and the status register only and gates nothing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      policy <= '0;
      lock_byte <= `LOCK_RST;
    end else if (clk_en) begin
      lock_byte <= lock;
      policy.flash_write_blocked <= lock_pair(lock, `LOCK_MEM_LSB) != 2'b11;
      policy.fuse_locked <= lock_pair(lock, `LOCK_MEM_LSB) != 2'b11;
      policy.flash_verify_blocked <= lock_pair(lock, `LOCK_MEM_LSB) == 2'b00;
      policy.self_program_write_blocked <= lock_pair(lock, `LOCK_APP_LSB) != 2'b11;
      policy.program_memory_read_blocked <= lock_pair(lock, `LOCK_APP_LSB) == 2'b00;
      policy.irq_suppress <= lock_pair(lock, `LOCK_APP_LSB) == 2'b00
        && ivec_in_boot && exec_in_app;
    end
  end

  // ----------------------------------------
  // read-back onto the data bus
  // ----------------------------------------
  // one cycle behind output-enable; bus released when it returns high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else if (clk_en) begin
      data_oe <= 1'b0;
      data_out <= 8'h00;
      if (!pins.output_enable_n) begin
        if (cmd == `CMD_READ_CAL && pins.byte_select) begin
          data_oe <= 1'b1;
          data_out <= (addr_lo <= 8'h03) ? cal[addr_lo[1:0]*8 +: 8] : 8'h00;
        end else if (cmd == `CMD_READ_FLASH && !policy.flash_verify_blocked) begin
          data_oe <= 1'b1;
          data_out <= pins.byte_select ? flash_mem[word_addr][15:8]
            : flash_mem[word_addr][7:0];
        end
      end
    end
  end

  assign ready_busy_out = ~busy;

  // ----------------------------------------
  // apb registers
  // ----------------------------------------
  logic apb_wr; // write access phase
  logic mapped; // address decodes
  assign apb_wr = psel && penable && pwrite;
  assign mapped = paddr == `REG_STATUS || paddr == `REG_CAL || paddr == `REG_PROG_TIME;
  assign pready = 1'b1; // zero wait states
  assign pslverr = psel && penable && !mapped;

  // writable control; status is read-only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cal <= `CAL_RST;
      prog_time <= `PROG_TIME_RST;
    end else if (clk_en && apb_wr) begin
      if (paddr == `REG_CAL) begin
        cal <= pwdata;
      end else if (paddr == `REG_PROG_TIME) begin
        prog_time <= pwdata[15:0];
      end
    end
  end

  // read data registered in the setup phase, valid in the access phase
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable) begin
      case (paddr)
        `REG_STATUS: begin
          prdata <= 32'h0000_0000;
          prdata[`ST_LOCK_LSB +: 8] <= lock;
          prdata[`ST_BUSY_BIT] <= busy;
          prdata[`ST_CMD_LSB +: 8] <= cmd;
        end
        `REG_CAL: prdata <= cal;
        `REG_PROG_TIME: prdata <= {16'h0000, prog_time};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** hdl/flash_port_consts.svh ***
// offsets, field positions, reset values and command codes of the programming port
`ifndef FLASH_PORT_CONSTS_SVH
`define FLASH_PORT_CONSTS_SVH

// ----------------------------------------
// apb register offsets
// ----------------------------------------
`define REG_STATUS 12'h000
`define REG_CAL 12'h004
`define REG_PROG_TIME 12'h008

// ----------------------------------------
// status fields
// ----------------------------------------
`define ST_LOCK_LSB 0
`define ST_BUSY_BIT 8
`define ST_CMD_LSB 16

// ----------------------------------------
// lock byte layout
// ----------------------------------------
`define LOCK_RST 8'hff
`define LOCK_UNUSED_MASK 8'hc0
`define LOCK_BOOT_LSB 4
`define LOCK_APP_LSB 2
`define LOCK_MEM_LSB 0

// ----------------------------------------
// programming commands
// ----------------------------------------
`define CMD_WRITE_FLASH 8'h10
`define CMD_READ_CAL 8'h08
`define CMD_CHIP_ERASE 8'h80
`define CMD_WRITE_LOCK 8'h20
`define CMD_READ_FLASH 8'h02

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define CAL_RST 32'h0000_0000
`define PROG_TIME_RST 16'h0100
`define ERASED_WORD 16'hffff

`endif

// *** hdl/flash_port_pkg.sv ***
// types shared by the parallel programming port
`default_nettype none
package flash_port_pkg;
  // programmer pins, all taken as synchronous to clk_sys
  typedef struct packed {
    logic load_select_high;
    logic load_select_low;
    logic byte_select;
    logic load_strobe_clock_input;
    logic page_latch_strobe;
    logic write_strobe_n;
    logic output_enable_n;
    logic [7:0] data;
  } prog_pins_t;

  // restrictions handed to the core
  typedef struct packed {
    logic flash_write_blocked;
    logic flash_verify_blocked;
    logic fuse_locked;
    logic self_program_write_blocked;
    logic program_memory_read_blocked;
    logic irq_suppress;
  } lock_policy_t;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PROG = 3'b010,
    ST_ERASE = 3'b100
  } seq_state_t;
endpackage
`default_nettype wire

// *** testbench/flash_port_assertions.sv ***
// checker watching the ports of the parallel programming port
`include "flash_port_consts.svh"
`default_nettype none
module flash_port_assertions #(
  parameter int FLASH_WORDS = 256,
  parameter int PAGE_WORDS = 32
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire flash_port_pkg::prog_pins_t pins,
  input wire logic data_oe,
  input wire logic ready_busy_out,
  input wire logic ivec_in_boot,
  input wire logic exec_in_app,
  input wire flash_port_pkg::lock_policy_t policy,
  input wire logic [7:0] lock_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // policy is registered, so only judged once the lock byte has settled
  AST_UNUSED: assert property (lock_byte[7:6] == 2'b11)
    else $error("unused lock bits not one");
  // lock_byte lags the lock by one edge, so the busy erase is two samples back
  AST_NO_SET: assert property ((lock_byte & ~$past(lock_byte)) != 8'h00
    |-> !$past(ready_busy_out, 2)) else $error("lock bit set outside erase");
  AST_MEM10: assert property ($stable(lock_byte) && lock_byte[1:0] == 2'b10
    |-> policy.flash_write_blocked && policy.fuse_locked && !policy.flash_verify_blocked)
    else $error("mem pair 10 policy wrong");
  AST_MEM00: assert property ($stable(lock_byte) && lock_byte[1:0] == 2'b00
    |-> policy.flash_write_blocked && policy.fuse_locked && policy.flash_verify_blocked)
    else $error("mem pair 00 policy wrong");
  AST_APP00: assert property ($stable(lock_byte) && lock_byte[3:2] == 2'b00
    |-> policy.self_program_write_blocked && policy.program_memory_read_blocked)
    else $error("app pair 00 policy wrong");
  AST_IRQ: assert property ($stable(lock_byte) && $stable(ivec_in_boot)
    && $stable(exec_in_app) |-> policy.irq_suppress
    == (lock_byte[3:2] == 2'b00 && ivec_in_boot && exec_in_app)) else $error("irq gate wrong");
  AST_BUSY: assert property ($fell(ready_busy_out)
    |-> $past(pins.write_strobe_n, 2) && !$past(pins.write_strobe_n))
    else $error("busy without write strobe");
  AST_SLVERR: assert property (psel && penable
    |-> pslverr == !(paddr inside {`REG_STATUS, `REG_CAL, `REG_PROG_TIME}))
    else $error("pslverr wrong");
  AST_ERR_DATA: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read data not zero");
  AST_OE: assert property (data_oe |-> !$past(pins.output_enable_n))
    else $error("data driven without output enable");
  cover property ($fell(ready_busy_out));
  cover property ($rose(data_oe));
  cover property (psel && penable && pslverr);
endmodule
bind flash_programming_port flash_port_assertions #(.FLASH_WORDS(FLASH_WORDS),
  .PAGE_WORDS(PAGE_WORDS)) flash_port_assertions_i (.clk_sys, .rst_n, .psel, .penable,
  .pwrite, .paddr, .prdata, .pslverr, .pins, .data_oe, .ready_busy_out, .ivec_in_boot,
  .exec_in_app, .policy, .lock_byte);
`default_nettype wire

// *** testbench/prog_model.sv ***
// programmer model driving the parallel programming pins
`default_nettype none
module prog_model (
  input wire logic clk_sys,
  output flash_port_pkg::prog_pins_t pins,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic ready_busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins = 15'h0300; // strobes low, write and output enable high
  // one load pulse, lines held on both sides of the strobe
  task automatic ld(input logic [1:0] sel, input logic bs, input logic [7:0] d);
    @(posedge clk_sys);
    {pins.load_select_high, pins.load_select_low} <= sel;
    pins.byte_select <= bs;
    pins.data <= d;
    @(posedge clk_sys);
    pins.load_strobe_clock_input <= 1'b1;
    @(posedge clk_sys);
    pins.load_strobe_clock_input <= 1'b0;
    pins.data <= ~d; // released bus never shows the stale byte
  endtask
  // page latch pulse with high byte selected
  task automatic latch();
    @(posedge clk_sys);
    pins.byte_select <= 1'b1;
    @(posedge clk_sys);
    pins.page_latch_strobe <= 1'b1;
    @(posedge clk_sys);
    pins.page_latch_strobe <= 1'b0;
  endtask
  // write pulse, then counts busy cycles; gives up quickly when none come
  task automatic prog(output int n);
    n = 0;
    @(posedge clk_sys);
    pins.byte_select <= 1'b0;
    @(posedge clk_sys);
    pins.write_strobe_n <= 1'b0;
    @(posedge clk_sys);
    pins.write_strobe_n <= 1'b1;
    for (int i = 0; i < 300; i++) begin
      @(negedge clk_sys);
      if (ready_busy_out === 1'b0) n++;
      else if (n > 0 || i > 8) break;
    end
  endtask
  // output enable low, sample once settled, then release
  task automatic rd(input logic bs, output logic [7:0] b, output logic oe);
    @(posedge clk_sys);
    pins.byte_select <= bs;
    pins.output_enable_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    b = data_out;
    oe = data_oe;
    @(posedge clk_sys);
    pins.output_enable_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_flash_programming_port.sv ***
// self-checking bench for the parallel programming port
`include "flash_port_consts.svh"
`default_nettype none
module tb_flash_programming_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic ivec_in_boot = 1'b0;
  logic exec_in_app = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  flash_port_pkg::prog_pins_t pins;
  logic [7:0] data_out;
  logic data_oe;
  logic ready_busy_out;
  flash_port_pkg::lock_policy_t policy;
  logic [7:0] lock_byte;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  logic [31:0] r;
  logic er;
  logic [7:0] b;
  logic oe;
  // register reads: address, expected data, expected refusal
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic e;} row_t;
  row_t rows [4] = '{'{`REG_STATUS, 32'hff, 1'b0}, '{`REG_CAL, `CAL_RST, 1'b0},
    '{`REG_PROG_TIME, 32'h100, 1'b0}, '{12'h00c, 32'h0, 1'b1}};
  initial forever #4 clk_sys = ~clk_sys;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  flash_programming_port #(.FLASH_WORDS(256), .PAGE_WORDS(32)) flash_programming_port_i (
    .clk_sys, .rst_n, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pins, .data_out, .data_oe, .ready_busy_out, .ivec_in_boot,
    .exec_in_app, .policy, .lock_byte);
  prog_model prog_model_i (.clk_sys, .pins, .data_out, .data_oe, .ready_busy_out);
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // apb transfer held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // wait states end only when pready comes; the hang guard ends a dead slave
    while (pready !== 1'b1) @(posedge clk_sys);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // flash word read back through the pins
  task automatic rdw(input logic [7:0] a, input logic [15:0] e, input logic eoe);
    prog_model_i.ld(2'b10, 1'b0, `CMD_READ_FLASH);
    prog_model_i.ld(2'b00, 1'b0, a);
    prog_model_i.rd(1'b0, b, oe);
    if (eoe) chk("word lo", 32'(b), 32'(e[7:0]));
    prog_model_i.rd(1'b1, b, oe);
    if (eoe) chk("word hi", 32'(b), 32'(e[15:8]));
    chk("data_oe", 32'(oe), 32'(eoe));
  endtask
  task automatic lk(input logic [7:0] d);
    prog_model_i.ld(2'b10, 1'b0, `CMD_WRITE_LOCK);
    prog_model_i.ld(2'b01, 1'b0, d);
    prog_model_i.prog(n);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk("lock_byte", 32'(lock_byte), 32'hff);
    chk("policy", 32'(policy), 32'h0);
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk("prdata", r, rows[i].d);
      chk("pslverr", 32'(er), 32'(rows[i].e));
    end
    apb(1'b1, `REG_PROG_TIME, 32'h4);
    apb(1'b1, `REG_CAL, 32'h4433_2211);
    prog_model_i.ld(2'b10, 1'b0, `CMD_READ_CAL);
    for (int i = 0; i < 4; i++) begin
      prog_model_i.ld(2'b00, 1'b0, 8'(i));
      prog_model_i.rd(1'b1, b, oe);
      chk("cal", 32'(b), 32'(i + 1) * 32'h11);
    end
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("command", 32'(r[23:16]), 32'(`CMD_READ_CAL));
    prog_model_i.ld(2'b10, 1'b0, `CMD_WRITE_FLASH);
    for (int i = 0; i < 2; i++) begin
      prog_model_i.ld(2'b00, 1'b0, 8'h25 + 8'(i));
      prog_model_i.ld(2'b01, 1'b0, 8'h34 + 8'(i));
      prog_model_i.ld(2'b01, 1'b1, 8'h12);
      prog_model_i.latch();
    end
    prog_model_i.ld(2'b00, 1'b1, 8'h00);
    prog_model_i.prog(n);
    chk("busy cycles", 32'(n), 32'd5);
    rdw(8'h25, 16'h1234, 1'b1);
    rdw(8'h26, 16'h1235, 1'b1);
    ivec_in_boot <= 1'b1;
    exec_in_app <= 1'b1;
    // unused bits written 0 must stay 1; boot pair 00 must gate nothing
    lk(8'h02);
    chk("lock_byte", 32'(lock_byte), 32'hc2);
    chk("policy", 32'(policy), 32'h2f);
    lk(8'hff);
    chk("lock_byte", 32'(lock_byte), 32'hc2);
    prog_model_i.ld(2'b10, 1'b0, `CMD_WRITE_FLASH);
    prog_model_i.ld(2'b01, 1'b0, 8'h00);
    prog_model_i.latch();
    prog_model_i.prog(n);
    chk("busy cycles", 32'(n), 32'd0);
    rdw(8'h26, 16'h1235, 1'b1);
    ivec_in_boot <= 1'b0;
    lk(8'hf0);
    chk("policy", 32'(policy), 32'h3e);
    rdw(8'h25, 16'h0000, 1'b0);
    prog_model_i.ld(2'b10, 1'b0, `CMD_CHIP_ERASE);
    prog_model_i.prog(n);
    chk("busy cycles", 32'(n), 32'd5);
    // lock_byte is a registered copy, one edge behind the lock restore
    @(negedge clk_sys);
    chk("lock_byte", 32'(lock_byte), 32'hff);
    rdw(8'h25, `ERASED_WORD, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
